// ### include/relay_matrix_defines.vh
// Constants for the relay matrix display driver: offsets, codes and bit positions.
// Assumes inclusion by bare name from the design files.
`ifndef RELAY_MATRIX_DEFINES_VH
`define RELAY_MATRIX_DEFINES_VH

// Register byte offsets.
`define OFS_DISPLAY_WORD 8'h00
`define OFS_ALARM_WORD 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_CLEAR 8'h0C
`define OFS_INT_ENABLE 8'h10
`define OFS_DISCRETE_STATUS 8'h14

// Reset values.
`define RST_ALARM_WORD 5'h00
`define RST_INT_ENABLE 4'h0
`define RST_ROW 11'h000

// Display word layout: row code in word bits 14..11, columns in 10..0.
`define ROW_CODE_MSB 14
`define ROW_CODE_LSB 11
`define COL_MSB 10

// Row codes per row number.
`define CODE_ROW1 4'h1
`define CODE_ROW2 4'h2
`define CODE_ROW3 4'h3
`define CODE_ROW4 4'h4
`define CODE_ROW5 4'h5
`define CODE_ROW6 4'h6
`define CODE_ROW7 4'hC
`define CODE_ROW8 4'h7
`define CODE_ROW9 4'h8
`define CODE_ROW10 4'h9
`define CODE_ROW11 4'hA
`define CODE_ROW12 4'hB
`define CODE_ROW13 4'hE

// Column index (column bit minus one) of special relays.
`define COL_SPECIAL 10
`define COL_INERTIAL_FAIL 7
`define COL_ACCEL_FAIL 6
`define COL_ANGLE_FAIL 5
`define COL_ENCODER_ZERO 4

// Alarm word bits.
`define AW_CHECK_FAIL 0
`define AW_TELEMETRY_FAIL 1
`define AW_PROGRAM_ALARM 2
`define AW_KEY_RELEASE 3
`define AW_COMP_ACTIVITY 4

// Interrupt status bits.
`define IRQ_NAV_DISCRETE 0
`define IRQ_FAILURE_FLAG 1
`define IRQ_COMP_FAIL 2
`define IRQ_BAD_ROW 3

`endif

// ### verilog/flash_pacer.v
// Flash pacer: toggles the verb and noun display phase on each timing request.
// Assumes the timing request comes from logic on clk_sys.
`timescale 1ns/1ps
module flash_pacer (
    input wire clk_sys,
    input wire rst_n,
    input wire flash_timing_request,
    input wire flash_enable_relay,
    output wire verb_noun_lit
);
    // Previous sample of the timing request, for edge detection.
    reg request_prev;
    // Current display phase; high means the displays are lit.
    reg phase;

    // The phase toggles on each rising request edge while flashing is enabled.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            request_prev <= 1'b0;
            phase <= 1'b1;
        end else begin
            request_prev <= flash_timing_request;
            if (!flash_enable_relay) begin
                // Without flashing the displays stay steadily lit.
                phase <= 1'b1;
            end else if (flash_timing_request && !request_prev) begin
                phase <= ~phase;
            end
        end
    end

    // The phase drives the verb and noun gating directly.
    assign verb_noun_lit = phase;
endmodule

// ### verilog/alarm_relays.v
// Alarm relays: nonlatching followers of the alarm word and alarm control inputs.
// Assumes all inputs are levels from logic on the same clock.
`timescale 1ns/1ps
`include "relay_matrix_defines.vh"
module alarm_relays (
    input wire [4:0] alarm_output_word,
    input wire [4:0] alarm_control,
    output wire check_failure_alarm,
    output wire telemetry_failure_alarm,
    output wire program_alarm,
    output wire key_release_indicator,
    output wire computer_activity_indicator,
    output wire [4:0] control_alarm_relays,
    output wire computer_failure_indicator
);
    // Each relay follows its input with no stored state.
    assign check_failure_alarm = alarm_output_word[`AW_CHECK_FAIL];
    assign telemetry_failure_alarm = alarm_output_word[`AW_TELEMETRY_FAIL];
    assign program_alarm = alarm_output_word[`AW_PROGRAM_ALARM];
    assign key_release_indicator = alarm_output_word[`AW_KEY_RELEASE];
    assign computer_activity_indicator = alarm_output_word[`AW_COMP_ACTIVITY];
    assign control_alarm_relays = alarm_control;

    // The check failure, the program alarm and every control alarm light the failure indicator.
    assign computer_failure_indicator = check_failure_alarm | program_alarm
        | (|alarm_control);
endmodule

// ### verilog/relay_matrix_display_driver.v
// Relay matrix display driver: 13 by 11 latching relays, alarm relays, register port.
// Assumes a single-cycle register master on clk_sys and same-clock alarm and timing inputs.
//
// How it works
// - Word bits 14..11 pick one relay row.
// - Code 0001 selects row one.
// - Only the selected row changes; all its columns load.
// - Matrix relays latch until readdressed.
// - Rows 7 and 13 drive discretes, not displays.
// - Columns 10..6 and 5..1 encode two digits.
// - Column 11 means sign, uplink or flash.
// - Flash toggles verb/noun at timing request rate.
// - Row 13 relays drive navigation discretes.
// - Any navigation discrete sets input bit 15.
// - Row 7 drives failure flags and encoder_zero_command.
// - Failure flags also go to annunciator.
// - Alarm relays follow inputs, never latch.
// - Alarms from alarm word and control logic.
// - Failure indicator ORs check fail, program alarm and controls.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "relay_matrix_defines.vh"
module relay_matrix_display_driver #(
    parameter ROWS = 13,
    parameter COLS = 11
) (
    input wire clk_sys,
    input wire rst_n,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata,
    // Timing and alarm control inputs from the computer.
    input wire flash_timing_request,
    input wire [4:0] alarm_control,
    // Relay matrix outputs, row r at bits r*11 upward, flash gating applied.
    output wire [142:0] display_relays,
    output wire flash_enable_relay,
    output wire uplink_activity_indicator,
    output wire [5:0] sign_relays,
    output wire [10:0] navigation_discretes,
    output wire input_word3_bit15,
    output wire inertial_unit_failure,
    output wire accelerometer_failure,
    output wire angle_converter_failure,
    output wire encoder_zero_command,
    output wire [2:0] annunciator_failures,
    // Alarm relay outputs.
    output wire check_failure_alarm,
    output wire telemetry_failure_alarm,
    output wire program_alarm,
    output wire key_release_indicator,
    output wire computer_activity_indicator,
    output wire [4:0] control_alarm_relays,
    output wire computer_failure_indicator,
    output wire irq
);
    // Latched relay state of all rows, row r at bits r*11 upward.
    wire [142:0] matrix_state;
    // Stored alarm output word.
    reg [4:0] alarm_output_word;
    // Sticky interrupt status and its enable mask.
    reg [3:0] int_status;
    reg [3:0] int_enable;
    // Previous levels for rising-edge event detection.
    reg nav_any_prev;
    reg fail_any_prev;
    reg comp_fail_prev;
    // Decoded row of the current word and whether its code is defined.
    reg [3:0] row_index;
    reg row_valid;
    // Write strobe for the display word register.
    wire word_write;
    // Combined failure flag level and verb/noun flash phase.
    wire fail_any;
    wire verb_noun_lit;
    // Next interrupt status and the events that set it.
    reg [3:0] next_int_status;
    wire [3:0] int_event;
    // Clear mask from a write of the clear register.
    wire [3:0] int_clear;

    assign word_write = reg_write && (reg_addr == `OFS_DISPLAY_WORD);

    // Row decoder: word bits 14..11 map to one of thirteen rows.
    always @* begin
        row_valid = 1'b1;
        case (reg_wdata[`ROW_CODE_MSB:`ROW_CODE_LSB])
            `CODE_ROW1: begin
                row_index = 4'h0;
            end
            `CODE_ROW2: begin
                row_index = 4'h1;
            end
            `CODE_ROW3: begin
                row_index = 4'h2;
            end
            `CODE_ROW4: begin
                row_index = 4'h3;
            end
            `CODE_ROW5: begin
                row_index = 4'h4;
            end
            `CODE_ROW6: begin
                row_index = 4'h5;
            end
            `CODE_ROW7: begin
                row_index = 4'h6;
            end
            `CODE_ROW8: begin
                row_index = 4'h7;
            end
            `CODE_ROW9: begin
                row_index = 4'h8;
            end
            `CODE_ROW10: begin
                row_index = 4'h9;
            end
            `CODE_ROW11: begin
                row_index = 4'hA;
            end
            `CODE_ROW12: begin
                row_index = 4'hB;
            end
            `CODE_ROW13: begin
                row_index = 4'hC;
            end
            default: begin
                // Undefined codes select nothing.
                row_index = 4'hF;
                row_valid = 1'b0;
            end
        endcase
    end

    // One bank of latching relays per row.
    genvar r;
    generate
        for (r = 0; r < ROWS; r = r + 1) begin : g_row
            localparam [3:0] ROW_ID = r;
            // Relay contacts of this row; they hold until the row is written again.
            reg [10:0] row_state;
            // The whole row is loaded, so zero columns release their relays.
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    row_state <= `RST_ROW;
                end else if (word_write && row_valid && (row_index == ROW_ID)) begin
                    row_state <= reg_wdata[`COL_MSB:0];
                end
            end
            assign matrix_state[r*COLS +: COLS] = row_state;
        end
    endgenerate

    // Row 13 relays are the navigation discretes, lowest column first.
    assign navigation_discretes = matrix_state[12*COLS +: COLS];
    assign input_word3_bit15 = |navigation_discretes;

    // Row 7 carries failure flags and the encoder_zero_command command.
    assign inertial_unit_failure = matrix_state[6*COLS + `COL_INERTIAL_FAIL];
    assign accelerometer_failure = matrix_state[6*COLS + `COL_ACCEL_FAIL];
    assign angle_converter_failure = matrix_state[6*COLS + `COL_ANGLE_FAIL];
    assign encoder_zero_command = matrix_state[6*COLS + `COL_ENCODER_ZERO];
    assign annunciator_failures = {inertial_unit_failure, accelerometer_failure,
        angle_converter_failure};
    assign fail_any = |annunciator_failures;

    // Column 11 meaning depends on the row: signs, uplink or flash.
    assign sign_relays = {matrix_state[7*COLS + `COL_SPECIAL],
        matrix_state[5*COLS + `COL_SPECIAL], matrix_state[4*COLS + `COL_SPECIAL],
        matrix_state[3*COLS + `COL_SPECIAL], matrix_state[1*COLS + `COL_SPECIAL],
        matrix_state[0*COLS + `COL_SPECIAL]};
    assign uplink_activity_indicator = matrix_state[8*COLS + `COL_SPECIAL];
    assign flash_enable_relay = matrix_state[10*COLS + `COL_SPECIAL];

    // Flash pacer gates the verb and noun displays.
    flash_pacer u_flash_pacer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flash_timing_request(flash_timing_request),
        .flash_enable_relay(flash_enable_relay),
        .verb_noun_lit(verb_noun_lit)
    );

    // Display drive: rows 10 and 11 digit columns blank in the dark flash phase.
    // Each display row carries two digit codes in columns 10..6 and 5..1.
    assign display_relays = {matrix_state[142:120],
        matrix_state[119:110] & {10{verb_noun_lit}},
        matrix_state[109:109], matrix_state[108:99] & {10{verb_noun_lit}},
        matrix_state[98:0]};

    // Alarm relays follow the stored alarm word and the alarm control levels.
    alarm_relays u_alarm_relays (
        .alarm_output_word(alarm_output_word),
        .alarm_control(alarm_control),
        .check_failure_alarm(check_failure_alarm),
        .telemetry_failure_alarm(telemetry_failure_alarm),
        .program_alarm(program_alarm),
        .key_release_indicator(key_release_indicator),
        .computer_activity_indicator(computer_activity_indicator),
        .control_alarm_relays(control_alarm_relays),
        .computer_failure_indicator(computer_failure_indicator)
    );

    // Alarm word and interrupt enable registers written by software.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_output_word <= `RST_ALARM_WORD;
            int_enable <= `RST_INT_ENABLE;
        end else if (reg_write) begin
            if (reg_addr == `OFS_ALARM_WORD) begin
                // Computer supplies its alarms through this word.
                alarm_output_word <= reg_wdata[4:0];
            end
            if (reg_addr == `OFS_INT_ENABLE) begin
                int_enable <= reg_wdata[3:0];
            end
        end
    end

    // Events: rising discrete summary, failure flag, failure indicator, bad row code.
    assign int_event = {word_write && !row_valid,
        computer_failure_indicator && !comp_fail_prev,
        fail_any && !fail_any_prev,
        input_word3_bit15 && !nav_any_prev};
    assign int_clear = (reg_write && (reg_addr == `OFS_INT_CLEAR)) ?
        reg_wdata[3:0] : 4'h0;

    // A set in the same cycle as its clear wins.
    always @* begin
        next_int_status = (int_status & ~int_clear) | int_event;
    end

    // Sticky status and edge history.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_status <= 4'h0;
            nav_any_prev <= 1'b0;
            fail_any_prev <= 1'b0;
            comp_fail_prev <= 1'b0;
        end else begin
            int_status <= next_int_status;
            nav_any_prev <= input_word3_bit15;
            fail_any_prev <= fail_any;
            comp_fail_prev <= computer_failure_indicator;
        end
    end

    // Level interrupt while an enabled status bit is set.
    assign irq = |(int_status & int_enable);

    // Read data stand for one cycle after the read strobe; otherwise zero.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                `OFS_ALARM_WORD: begin
                    reg_rdata <= {27'h000_0000, alarm_output_word};
                end
                `OFS_INT_STATUS: begin
                    reg_rdata <= {28'h000_0000, int_status};
                end
                `OFS_INT_ENABLE: begin
                    reg_rdata <= {28'h000_0000, int_enable};
                end
                `OFS_DISCRETE_STATUS: begin
                    // Navigation discretes, summary, then row 7 outputs.
                    reg_rdata <= {16'h0000, encoder_zero_command, annunciator_failures,
                        input_word3_bit15, navigation_discretes};
                end
                default: begin
                    // Write-only and unmapped offsets read as zero.
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

// ### dv/relay_matrix_monitor.sv
// Checker for the relay matrix display driver, watching its top-level ports only.
// Assumes it is bound onto the driver from the bench top file.
`timescale 1ns/1ps
`include "relay_matrix_defines.vh"
module relay_matrix_monitor (
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire [142:0] display_relays,
    input wire [10:0] navigation_discretes,
    input wire input_word3_bit15,
    input wire [4:0] alarm_control,
    input wire [4:0] control_alarm_relays,
    input wire check_failure_alarm,
    input wire program_alarm,
    input wire computer_failure_indicator
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A write to the display word and the row code it carries.
    wire disp_wr = reg_write && (reg_addr == `OFS_DISPLAY_WORD);
    wire [3:0] code = reg_wdata[14:11];
    // True for codes that name no row.
    wire bad_code = (code == 4'h0) || (code == 4'hD) || (code == 4'hF);
    property p_row1_load;
        disp_wr && code == 4'h1 |=> display_relays[10:0] == $past(reg_wdata[10:0]);
    endproperty
    a_row1_load: assert property (p_row1_load) else $error("row one not loaded");
    property p_row13_load;
        disp_wr && code == 4'hE |=> navigation_discretes == $past(reg_wdata[10:0]);
    endproperty
    a_row13_load: assert property (p_row13_load) else $error("nav row not loaded");
    property p_other_rows;
        disp_wr && code == 4'h1 |=> $stable(display_relays[98:11]) && $stable(navigation_discretes);
    endproperty
    a_other_rows: assert property (p_other_rows) else $error("unselected row moved");
    property p_latch;
        !reg_write |=> $stable(display_relays[98:0]);
    endproperty
    a_latch: assert property (p_latch) else $error("relay moved without a write");
    property p_bad_row;
        disp_wr && bad_code |=> $stable(display_relays[98:0]) && $stable(navigation_discretes);
    endproperty
    a_bad_row: assert property (p_bad_row) else $error("undefined row moved relays");
    property p_summary;
        input_word3_bit15 == (|navigation_discretes);
    endproperty
    a_summary: assert property (p_summary) else $error("nav summary wrong");
    property p_follow;
        control_alarm_relays == alarm_control;
    endproperty
    a_follow: assert property (p_follow) else $error("alarm relay not following");
    property p_fail_lamp;
        computer_failure_indicator == (check_failure_alarm | program_alarm | (|alarm_control));
    endproperty
    a_fail_lamp: assert property (p_fail_lamp) else $error("failure lamp wrong");
    // Main scenarios that the bench should reach.
    c_row1: cover property (disp_wr && code == 4'h1);
    c_bad: cover property (disp_wr && bad_code);
    c_nav: cover property ($rose(input_word3_bit15));
endmodule

// ### dv/flight_computer_model.sv
// Flight computer stand-in: paces the slow flash timing level and drives alarm control.
// Assumes the bench sets pace_on and alarm_set by non-blocking assignment on clk_sys.
`timescale 1ns/1ps
module flight_computer_model #(
    parameter HALF = 4
) (
    input wire clk_sys,
    input wire rst_n,
    input wire pace_on,
    input wire [4:0] alarm_set,
    output reg flash_timing_request,
    output reg [4:0] alarm_control
);
    // Clocks spent in the current half period of the timing level.
    reg [7:0] cnt;
    // The timing level runs only while pacing is asked for, and rests low otherwise.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            flash_timing_request <= 1'b0;
            alarm_control <= 5'h00;
        end else begin
            alarm_control <= alarm_set;
            if (!pace_on) begin
                cnt <= 8'h00;
                flash_timing_request <= 1'b0;
            end else if (cnt == HALF - 1) begin
                cnt <= 8'h00;
                flash_timing_request <= ~flash_timing_request;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// ### dv/relay_matrix_display_driver_tb_top.sv
// Bench top for the relay matrix display driver: clock, reset, bus tasks, scenarios.
// Assumes the computer model and the checker are compiled before this file.
`timescale 1ns/1ps
`include "relay_matrix_defines.vh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module relay_matrix_display_driver_tb_top;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0000_0000;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg pace_on = 1'b0;
    reg [4:0] alarm_set = 5'h00;
    wire flash_timing_request, flash_enable_relay, input_word3_bit15, inertial_unit_failure;
    wire computer_failure_indicator, irq, uplink_activity_indicator;
    wire [5:0] sign_relays;
    wire [4:0] alarm_control, control_alarm_relays, alarm_leds;
    wire [31:0] reg_rdata;
    wire [142:0] display_relays;
    wire [10:0] navigation_discretes;
    wire [2:0] annunciator_failures;
    integer mismatches = 0;
    integer tests_run = 0;
    logic [31:0] rv;
    logic [10:0] pat [0:12];
    logic [3:0] codes [0:12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hC, 4'h7, 4'h8,
                                 4'h9, 4'hA, 4'hB, 4'hE};
    // Half-period toggle gives 100 MHz.
    always #5 clk_sys = ~clk_sys;
    relay_matrix_display_driver DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .flash_timing_request(flash_timing_request), .alarm_control(alarm_control),
        .display_relays(display_relays), .flash_enable_relay(flash_enable_relay),
        .uplink_activity_indicator(uplink_activity_indicator), .sign_relays(sign_relays),
        .navigation_discretes(navigation_discretes),
        .input_word3_bit15(input_word3_bit15), .inertial_unit_failure(inertial_unit_failure),
        .accelerometer_failure(), .angle_converter_failure(), .encoder_zero_command(),
        .annunciator_failures(annunciator_failures), .check_failure_alarm(alarm_leds[0]),
        .telemetry_failure_alarm(alarm_leds[1]), .program_alarm(alarm_leds[2]),
        .key_release_indicator(alarm_leds[3]), .computer_activity_indicator(alarm_leds[4]),
        .control_alarm_relays(control_alarm_relays),
        .computer_failure_indicator(computer_failure_indicator), .irq(irq));
    flight_computer_model #(.HALF(4)) u_fc (
        .clk_sys(clk_sys), .rst_n(rst_n), .pace_on(pace_on), .alarm_set(alarm_set),
        .flash_timing_request(flash_timing_request), .alarm_control(alarm_control));
    // One-cycle write strobe; returns just after the edge that takes it.
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask
    // One-cycle read strobe; the data stand in the following cycle only.
    task automatic rd(input [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    // Every readable place, the write-only word and an unmapped one read zero after reset.
    task automatic t_reset;
        logic [7:0] a [0:5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h20};
        for (int i = 0; i < 6; i++) begin
            rd(a[i]);
            `CHK("reset read", 32'h0000_0000, rv)
        end
        $display("test reset done");
    endtask
    // Load every row through its code, then confirm each one held its own pattern.
    task automatic t_rows;
        for (int r = 0; r < 13; r++) begin
            pat[r] = 11'h2AA ^ 11'(r);
            wr(`OFS_DISPLAY_WORD, {17'h0_0000, codes[r], pat[r]});
            `CHK("row load", pat[r], display_relays[r*11 +: 11])
        end
        for (int r = 0; r < 13; r++) begin
            `CHK("row held", pat[r], display_relays[r*11 +: 11])
        end
        `CHK("nav discretes", pat[12], navigation_discretes)
        `CHK("nav summary", 1'b1, input_word3_bit15)
        `CHK("inertial fail", 1'b1, inertial_unit_failure)
        `CHK("annunciator", 3'b101, annunciator_failures)
        rd(`OFS_DISCRETE_STATUS);
        `CHK("discrete status", 32'h0000_5AA6, rv)
        wr(`OFS_DISPLAY_WORD, 32'h0000_0800);
        `CHK("row one released", 11'h000, display_relays[10:0])
        `CHK("row two kept", pat[1], display_relays[21:11])
        wr(`OFS_DISPLAY_WORD, 32'h0000_4400);
        `CHK("uplink lamp", 1'b1, uplink_activity_indicator)
        wr(`OFS_DISPLAY_WORD, 32'h0000_3C00);
        `CHK("row 8 sign", 6'h20, sign_relays)
        wr(`OFS_DISPLAY_WORD, 32'h0000_7000);
        `CHK("nav summary off", 1'b0, input_word3_bit15)
        $display("test rows done");
    endtask
    // Undefined codes move nothing; their event is masked, raised and cleared.
    task automatic t_bad;
        logic [142:0] keep;
        logic [3:0] bad [0:2] = '{4'h0, 4'hD, 4'hF};
        keep = display_relays;
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_DISPLAY_WORD, {17'h0_0000, bad[i], 11'h7FF});
            `CHK("bad row", keep, display_relays)
        end
        rd(`OFS_INT_STATUS);
        `CHK("bad row flag", 1'b1, rv[3])
        `CHK("masked irq", 1'b0, irq)
        wr(`OFS_INT_ENABLE, 32'h0000_0008);
        `CHK("raised irq", 1'b1, irq)
        rd(`OFS_INT_ENABLE);
        `CHK("enable readback", 32'h0000_0008, rv)
        wr(`OFS_INT_CLEAR, 32'h0000_000F);
        `CHK("cleared irq", 1'b0, irq)
        rd(`OFS_INT_STATUS);
        `CHK("status cleared", 32'h0000_0000, rv)
        $display("test bad rows done");
    endtask
    // Each alarm word bit and each control alarm, one at a time.
    task automatic t_alarm;
        for (int i = 0; i < 5; i++) begin
            // Drop the previous control alarm so only the word bit drives the lamp.
            @(posedge clk_sys);
            alarm_set <= 5'h00;
            wr(`OFS_ALARM_WORD, 32'(1 << i));
            `CHK("alarm relay", 5'(1 << i), alarm_leds)
            `CHK("word lamp", (i == 0 || i == 2), computer_failure_indicator)
            rd(`OFS_ALARM_WORD);
            `CHK("alarm readback", 32'(1 << i), rv)
            wr(`OFS_ALARM_WORD, 32'h0000_0000);
            @(posedge clk_sys);
            alarm_set <= 5'(1 << i);
            @(posedge clk_sys);
            #1;
            `CHK("control relay", 5'(1 << i), control_alarm_relays)
            `CHK("control lamp", 1'b1, computer_failure_indicator)
        end
        @(posedge clk_sys);
        alarm_set <= 5'h00;
        @(posedge clk_sys);
        #1;
        `CHK("lamp released", 1'b0, computer_failure_indicator)
        $display("test alarms done");
    endtask
    // Verb and noun digits blink with the timing level and come back lit when the flash relay is released.
    task automatic t_flash;
        wr(`OFS_DISPLAY_WORD, {17'h0_0000, 4'hA, 11'h555});
        `CHK("flash enable", 1'b1, flash_enable_relay)
        `CHK("lit digits", 10'h155, display_relays[119:110])
        @(posedge clk_sys);
        pace_on <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(posedge flash_timing_request);
            @(posedge clk_sys);
            #1;
            `CHK("verb phase", (k % 2) ? 10'h155 : 10'h000, display_relays[119:110])
            `CHK("noun phase", (k % 2) ? 10'h2A3 : 10'h000, display_relays[108:99])
            `CHK("flash column", 1'b1, display_relays[120])
        end
        @(posedge clk_sys);
        pace_on <= 1'b0;
        wr(`OFS_DISPLAY_WORD, {17'h0_0000, 4'hA, 11'h155});
        @(posedge clk_sys);
        #1;
        `CHK("flash off lit", 10'h155, display_relays[119:110])
        $display("test flash done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence: reset for 16 cycles, then every scenario in turn.
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_rows;
        t_bad;
        t_alarm;
        t_flash;
        print_verdict;
    end
    // Watchdog far beyond the roughly 155 cycles the scenarios need.
    initial begin
        #200000;
        mismatches++;
        $display("watchdog expired");
        print_verdict;
    end
endmodule
bind relay_matrix_display_driver relay_matrix_monitor u_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .display_relays(display_relays),
    .navigation_discretes(navigation_discretes), .input_word3_bit15(input_word3_bit15),
    .alarm_control(alarm_control), .control_alarm_relays(control_alarm_relays),
    .check_failure_alarm(check_failure_alarm), .program_alarm(program_alarm),
    .computer_failure_indicator(computer_failure_indicator));
